// ==== rtl/stcu_top.v ====
/*
 * serial thermostat command unit: collects host characters, decodes
 * commands, keeps setpoint, offset and control state, builds replies.
 * assumes a uart outside that writes received bytes to the rx register
 * and drains replies from the tx register over avalon-mm.
 */
`timescale 1ns/1ns
`default_nettype none
`include "stcu_regs.vh"

module stcu_top (
   input wire MCLK_I,
   input wire SYS_RST_I,
   input wire [4:0] AVS_ADDRESS_I,
   input wire AVS_READ_I,
   input wire AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [3:0] AVS_BYTEENABLE_I,
   output reg [31:0] AVS_READDATA_O,
   output reg AVS_WAITREQUEST_O,
   input wire [15:0] ACT_TEMP_I,
   input wire LINK_LOST_I,
   input wire FAULT_I,
   output reg [15:0] SETPOINT_O,
   output reg [15:0] OFFSET_O,
   output reg BARS_O,
   output reg REMOTE_O,
   output reg ENTER_BLOCK_O,
   output reg HEATER_O,
   output reg PUMP_O,
   output reg CTRL_RST_O
);

   // ****************************************
   // helpers
   // ****************************************
   function is_dig;
      input [7:0] c;
      begin
         is_dig = (c >= 8'h30) && (c <= 8'h39);
      end
   endfunction

   function [15:0] val4;
      input [7:0] a;
      input [7:0] b;
      input [7:0] c;
      input [7:0] d;
      begin
         val4 = (({12'h000, a[3:0]} * 16'd1000) + ({12'h000, b[3:0]} * 16'd100))
            + (({12'h000, c[3:0]} * 16'd10) + {12'h000, d[3:0]});
      end
   endfunction

   function [7:0] dec_digit;
      input [15:0] mag;
      input [2:0] pos;
      reg [15:0] q;
      reg [15:0] r;
      begin
         q = mag;
         case (pos)
            3'd1: q = mag / 16'd10;
            3'd2: q = mag / 16'd100;
            3'd3: q = mag / 16'd1000;
            3'd4: q = mag / 16'd10000;
            3'd5: q = 16'h0000;
            default: q = mag;
         endcase
         r = q % 16'd10;
         dec_digit = `STCU_ZERO + {4'h0, r[3:0]};
      end
   endfunction

   // sign, n integer digits, point, two fractions, _C$ cr lf
   function [7:0] temp_char;
      input [3:0] idx;
      input [15:0] v;
      input wide;
      reg [15:0] mag;
      reg [3:0] nd;
      reg [3:0] k;
      begin
         mag = v[15] ? (16'h0000 - v) : v;
         nd = wide ? 4'd6 : 4'd4;
         k = nd - idx;
         temp_char = 8'h00;
         if (idx == 4'd0) begin
            temp_char = v[15] ? `STCU_MINUS : `STCU_PLUS;
         end else if (idx <= nd - 4'd2) begin
            temp_char = dec_digit(mag, k[2:0]);
         end else if (idx == nd - 4'd1) begin
            temp_char = `STCU_DOT;
         end else if (idx <= nd + 4'd1) begin
            temp_char = dec_digit(mag, k[2:0] + 3'd1);
         end else begin
            case (idx - nd)
               4'd2: temp_char = `STCU_USC;
               4'd3: temp_char = 8'h43;
               4'd4: temp_char = `STCU_DOLLAR;
               4'd5: temp_char = `STCU_CR;
               4'd6: temp_char = `STCU_LF;
               default: temp_char = 8'h00;
            endcase
         end
      end
   endfunction

   // ****************************************
   // pin synchronisers
   // ****************************************
   reg [1:0] lost_sync_reg;
   reg [1:0] fault_sync_reg;
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         lost_sync_reg <= 2'b00;
         fault_sync_reg <= 2'b00;
      end else begin
         lost_sync_reg <= {lost_sync_reg[0], LINK_LOST_I};
         fault_sync_reg <= {fault_sync_reg[0], FAULT_I};
      end
   end
   wire link_lost = lost_sync_reg[1];
   wire fault = fault_sync_reg[1];

   // ****************************************
   // bus slave
   // ****************************************
   wire req = AVS_READ_I | AVS_WRITE_I;
   wire acc = req & ~AVS_WAITREQUEST_O;
   wire wr_acc = AVS_WRITE_I & acc;
   wire rx_push = wr_acc && (AVS_ADDRESS_I == `STCU_RXCHAR_OFS) && AVS_BYTEENABLE_I[0];
   wire tx_pop = AVS_READ_I && acc && (AVS_ADDRESS_I == `STCU_TXCHAR_OFS);
   // bytes arrive already deframed 8n1 by the uart outside
   wire [7:0] rx_char = AVS_WRITEDATA_I[7:0]; // see RULE25

   // ****************************************
   // state
   // ****************************************
   reg [7:0] buf_reg [0:`STCU_BUF_LEN-1];
   reg [3:0] len_reg;
   reg ovf_reg;
   reg [15:0] host_sp_reg;
   reg [15:0] host_ofs_reg;
   reg host_sp_v_reg;
   reg host_ofs_v_reg;
   // panel entries survive a power cycle, so no reset
   reg [15:0] key_sp_reg = `STCU_KEYSP_RST;
   reg [15:0] key_ofs_reg = `STCU_KEYOFS_RST;
   reg remote_reg;
   reg run_reg;
   reg alarm_reg;
   reg locked_reg;
   reg [2:0] rtype_reg;
   reg [3:0] ridx_reg;
   reg [15:0] rval_reg;

   wire [15:0] sp_eff = host_sp_v_reg ? host_sp_reg : key_sp_reg; // see RULE2
   wire [15:0] ofs_eff = host_ofs_v_reg ? host_ofs_reg : key_ofs_reg; // see RULE5

   // ****************************************
   // decoder
   // ****************************************
   wire eol = rx_push && (rx_char == `STCU_CR); // see RULE23
   wire [7:0] b0 = buf_reg[0];
   wire [7:0] b1 = buf_reg[1];
   wire len1 = (len_reg == 4'd1) && !ovf_reg;
   wire len2 = (len_reg == 4'd2) && !ovf_reg;
   // exact upper or lower case compares only
   wire cmd_ver = len1 && (b0 == 8'h56); // see RULE7
   wire cmd_act = len1 && (b0 == 8'h49);
   wire cmd_sq = len1 && (b0 == 8'h53);
   wire cmd_oq = len1 && (b0 == 8'h63);
   wire cmd_stq = len1 && (b0 == 8'h42);
   wire cmd_lock = len1 && (b0 == 8'h4C);
   wire cmd_unlock = len1 && (b0 == 8'h55);
   wire cmd_rst = len2 && (b0 == 8'h52) && (b1 == 8'h53);
   wire cmd_halt = len2 && (b0 == 8'h53) && (b1 == 8'h54);
   wire cmd_go = len2 && (b0 == 8'h47) && (b1 == 8'h4F);
   wire cmd_unl = len2 && (b0 == 8'h45) && (b1 == 8'h52);
   wire cmd_trip = len2 && (b0 == 8'h41) && (b1 == 8'h4C);

   // setpoint write: S, three spaces, five value characters
   wire sp_shape = (len_reg == 4'd9) && !ovf_reg && (b0 == 8'h53) && (b1 == `STCU_SP)
      && (buf_reg[2] == `STCU_SP) && (buf_reg[3] == `STCU_SP);
   wire sp_neg = buf_reg[4] == `STCU_MINUS; // see RULE13
   wire sp_digs = (sp_neg || is_dig(buf_reg[4])) && is_dig(buf_reg[5])
      && is_dig(buf_reg[6]) && is_dig(buf_reg[7]) && is_dig(buf_reg[8]);
   wire [15:0] sp_low = val4(buf_reg[5], buf_reg[6], buf_reg[7], buf_reg[8]);
   wire [15:0] sp_mag = sp_neg ? sp_low : ({12'h000, buf_reg[4][3:0]} * 16'd10000) + sp_low;
   // leading digit above 5 can wrap the 16-bit sum
   wire sp_inrange = sp_neg ? (sp_mag <= `STCU_SP_NEG_MAX)
      : ((buf_reg[4] <= 8'h32) && (sp_mag <= `STCU_SP_MAX)); // see RULE24
   wire cmd_sw = sp_shape && sp_digs && sp_inrange; // see RULE12
   wire [15:0] sp_val = sp_neg ? (16'h0000 - sp_mag) : sp_mag;

   // offset write: c, space, sign, four digits
   wire [7:0] osg = buf_reg[2];
   wire o_sign_ok = (osg == `STCU_SP) || (osg == `STCU_PLUS) || (osg == `STCU_MINUS); // see RULE16
   wire [15:0] o_mag = val4(buf_reg[3], buf_reg[4], buf_reg[5], buf_reg[6]);
   wire cmd_ow = (len_reg == 4'd7) && !ovf_reg && (b0 == 8'h63) && (b1 == `STCU_SP)
      && o_sign_ok && is_dig(buf_reg[3]) && is_dig(buf_reg[4]) && is_dig(buf_reg[5])
      && is_dig(buf_reg[6]) && (o_mag <= `STCU_OFS_MAX); // see RULE15
   wire [15:0] o_val = (osg == `STCU_MINUS) ? (16'h0000 - o_mag) : o_mag;

   // keypad writes from software, refused while enter is blocked
   wire key_sp_wr = wr_acc && (AVS_ADDRESS_I == `STCU_KEYSP_OFS) && !remote_reg;
   wire key_ofs_wr = wr_acc && (AVS_ADDRESS_I == `STCU_KEYOFS_OFS) && !remote_reg;

   // ****************************************
   // line collector
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < `STCU_BUF_LEN; gi = gi + 1) begin : g_buf
         always @(posedge MCLK_I) begin
            if (SYS_RST_I) begin
               buf_reg[gi] <= 8'h00;
            end else if (rx_push && !eol && (len_reg == gi) && !ovf_reg) begin
               buf_reg[gi] <= rx_char; // see RULE23
            end
         end
      end
   endgenerate

   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         len_reg <= 4'd0;
         ovf_reg <= 1'b0;
      end else if (eol) begin
         len_reg <= 4'd0;
         ovf_reg <= 1'b0;
      end else if (rx_push) begin
         if (len_reg == `STCU_BUF_LEN) begin
            ovf_reg <= 1'b1; // see RULE24
         end else begin
            len_reg <= len_reg + 4'd1;
         end
      end
   end

   // ****************************************
   // setpoint, offset and control state
   // ****************************************
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         // power cycle forgets host values, keypad values apply
         host_sp_v_reg <= 1'b0; // see RULE3
         host_ofs_v_reg <= 1'b0; // see RULE4
         host_sp_reg <= 16'h0000;
         host_ofs_reg <= 16'h0000; // see RULE6
         remote_reg <= 1'b0;
         run_reg <= 1'b0;
         alarm_reg <= 1'b0;
         locked_reg <= 1'b1;
         CTRL_RST_O <= 1'b0;
      end else begin
         CTRL_RST_O <= eol && cmd_rst; // see RULE9
         if (key_sp_wr) begin
            if (AVS_BYTEENABLE_I[0]) begin
               key_sp_reg[7:0] <= AVS_WRITEDATA_I[7:0];
            end
            if (AVS_BYTEENABLE_I[1]) begin
               key_sp_reg[15:8] <= AVS_WRITEDATA_I[15:8];
            end
            host_sp_v_reg <= 1'b0;
         end
         if (key_ofs_wr) begin
            if (AVS_BYTEENABLE_I[0]) begin
               key_ofs_reg[7:0] <= AVS_WRITEDATA_I[7:0];
            end
            if (AVS_BYTEENABLE_I[1]) begin
               key_ofs_reg[15:8] <= AVS_WRITEDATA_I[15:8];
            end
            host_ofs_v_reg <= 1'b0;
         end
         if (eol && cmd_sw) begin
            host_sp_reg <= sp_val; // see RULE12
            host_sp_v_reg <= 1'b1;
            remote_reg <= 1'b1;
         end
         if (eol && cmd_ow) begin
            host_ofs_reg <= o_val; // see RULE15
            host_ofs_v_reg <= 1'b1;
            remote_reg <= 1'b1;
         end
         if (eol && cmd_lock) begin
            remote_reg <= 1'b1; // see RULE21
         end
         if (eol && cmd_unlock) begin
            remote_reg <= 1'b0; // see RULE21
         end
         if (eol && cmd_halt) begin
            run_reg <= 1'b0; // see RULE17
         end
         if (eol && cmd_go) begin
            run_reg <= 1'b1; // see RULE18
         end
         if (fault || (eol && cmd_trip)) begin
            locked_reg <= 1'b1;
         end else if (eol && cmd_unl) begin
            locked_reg <= 1'b0; // see RULE19
         end
         if (eol && cmd_trip) begin
            alarm_reg <= 1'b1; // see RULE20
         end else if (eol && cmd_unl) begin
            alarm_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // reply generator
   // ****************************************
   reg [3:0] rlen;
   reg [7:0] rchar;
   always @* begin
      rlen = 4'd0;
      rchar = 8'h00;
      case (rtype_reg)
         `STCU_R_VER: begin
            rlen = 4'd8;
            case (ridx_reg)
               4'd0: rchar = 8'h56;
               4'd1: rchar = 8'h31;
               4'd2: rchar = `STCU_DOT;
               4'd3: rchar = 8'h30;
               4'd4: rchar = 8'h30;
               4'd5: rchar = `STCU_DOLLAR; // see RULE8
               4'd6: rchar = `STCU_CR;
               default: rchar = `STCU_LF;
            endcase
         end
         `STCU_R_ACT, `STCU_R_SET: begin
            rlen = 4'd13;
            rchar = temp_char(ridx_reg, rval_reg, 1'b1); // see RULE10 RULE11
         end
         `STCU_R_OFS: begin
            rlen = 4'd11;
            rchar = temp_char(ridx_reg, rval_reg, 1'b0); // see RULE14
         end
         `STCU_R_STAT: begin
            rlen = 4'd8;
            if (ridx_reg < 4'd5) begin
               rchar = `STCU_ZERO + {7'h00, rval_reg[ridx_reg]}; // see RULE22
            end else if (ridx_reg == 4'd5) begin
               rchar = `STCU_DOLLAR;
            end else if (ridx_reg == 4'd6) begin
               rchar = `STCU_CR;
            end else begin
               rchar = `STCU_LF;
            end
         end
         default: begin
            rlen = 4'd0;
            rchar = 8'h00;
         end
      endcase
   end
   wire tx_valid = ridx_reg < rlen;

   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         rtype_reg <= `STCU_R_NONE;
         ridx_reg <= 4'd0;
         rval_reg <= 16'h0000;
      end else if (eol && (cmd_ver || cmd_act || cmd_sq || cmd_oq || cmd_stq)) begin
         ridx_reg <= 4'd0;
         if (cmd_ver) begin
            rtype_reg <= `STCU_R_VER;
         end else if (cmd_act) begin
            rtype_reg <= `STCU_R_ACT;
            rval_reg <= ACT_TEMP_I;
         end else if (cmd_sq) begin
            rtype_reg <= `STCU_R_SET;
            rval_reg <= sp_eff;
         end else if (cmd_oq) begin
            rtype_reg <= `STCU_R_OFS;
            rval_reg <= ofs_eff;
         end else begin
            rtype_reg <= `STCU_R_STAT;
            rval_reg <= {11'h000, locked_reg, alarm_reg, run_reg, BARS_O, remote_reg};
         end
      end else if (tx_pop && tx_valid) begin
         ridx_reg <= ridx_reg + 4'd1;
      end
   end

   // ****************************************
   // bus answer and outputs
   // ****************************************
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O <= 32'h0000_0000;
      end else begin
         AVS_WAITREQUEST_O <= !(req && AVS_WAITREQUEST_O);
         if (AVS_READ_I && AVS_WAITREQUEST_O) begin
            case (AVS_ADDRESS_I)
               `STCU_TXCHAR_OFS: AVS_READDATA_O <= {23'h00_0000, tx_valid, rchar};
               `STCU_STATUS_OFS: AVS_READDATA_O <= {23'h00_0000, host_ofs_v_reg,
                  host_sp_v_reg, tx_valid, link_lost, locked_reg, alarm_reg, run_reg,
                  BARS_O, remote_reg};
               `STCU_SETPT_OFS: AVS_READDATA_O <= {16'h0000, sp_eff};
               `STCU_OFFSET_OFS: AVS_READDATA_O <= {16'h0000, ofs_eff};
               `STCU_KEYSP_OFS: AVS_READDATA_O <= {16'h0000, key_sp_reg};
               `STCU_KEYOFS_OFS: AVS_READDATA_O <= {16'h0000, key_ofs_reg};
               default: AVS_READDATA_O <= 32'h0000_0000;
            endcase
         end
      end
   end

   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         SETPOINT_O <= key_sp_reg; // see RULE3
         OFFSET_O <= key_ofs_reg; // see RULE6
         BARS_O <= 1'b0;
         REMOTE_O <= 1'b0;
         ENTER_BLOCK_O <= 1'b0;
         HEATER_O <= 1'b0;
         PUMP_O <= 1'b0;
      end else begin
         SETPOINT_O <= sp_eff; // see RULE2
         OFFSET_O <= ofs_eff; // see RULE5
         BARS_O <= host_sp_v_reg | host_ofs_v_reg; // see RULE1
         REMOTE_O <= remote_reg;
         ENTER_BLOCK_O <= remote_reg; // see RULE21
         HEATER_O <= run_reg && !locked_reg && !alarm_reg; // see RULE17
         PUMP_O <= !locked_reg && !alarm_reg; // see RULE20
      end
   end

endmodule
`default_nettype wire

// ==== inc/stcu_regs.vh ====
/*
 * register map, field positions, reset values and character codes of the
 * serial thermostat command unit.
 * assumes byte addresses on an avalon-mm slave with 32-bit data.
 */
// How it works
// RULE1 - host-written setpoint or offset turns the setpoint display into two bars
// RULE2 - link loss keeps regulation on the last host setpoint
// RULE3 - power cycle drops host setpoint, panel setpoint applies again
// RULE4 - host offset is held in volatile flops only
// RULE5 - link loss keeps the last host offset applied
// RULE6 - power cycle drops host offset, panel offset applies again
// RULE7 - command letters match case exactly, other case is unknown
// RULE8 - version query answers a version text ending in dollar
// RULE9 - two-letter restart command pulses a controller reset
// RULE10 - actual query answers sign, XXXX.XX, _C, dollar, cr, lf
// RULE11 - setpoint query answers in the actual-temperature format
// RULE12 - setpoint write 00000..20000 or -5000, goes remote, blocks enter
// RULE13 - host puts minus in place of first value character
// RULE14 - offset query answers sign, XX.XX, _C, dollar, cr, lf
// RULE15 - offset write sign plus 0000..0255, goes remote, blocks enter
// RULE16 - space or plus is a positive offset sign
// RULE17 - halt command stops control, heater off, pump keeps running
// RULE18 - resume command starts control
// RULE19 - fault unlock releases the locked state
// RULE20 - remote trip enters external alarm, heater and pump off
// RULE21 - lock enters remote and blocks enter, unlock leaves and releases
// RULE22 - state query answers the operating status
// RULE23 - characters collect until carriage return, then decode
// RULE24 - unknown or out-of-range commands change nothing
// RULE25 - 8n1 framing at panel baud rate, handled outside this block
`ifndef STCU_REGS_VH
`define STCU_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define STCU_RXCHAR_OFS 5'h00
`define STCU_TXCHAR_OFS 5'h04
`define STCU_STATUS_OFS 5'h08
`define STCU_SETPT_OFS 5'h0C
`define STCU_OFFSET_OFS 5'h10
`define STCU_KEYSP_OFS 5'h14
`define STCU_KEYOFS_OFS 5'h18

// ****************************************
// fields
// ****************************************
`define STCU_TX_VALID_BIT 8
`define STCU_SB_REMOTE 0
`define STCU_SB_BARS 1
`define STCU_SB_RUN 2
`define STCU_SB_ALARM 3
`define STCU_SB_LOCKED 4
`define STCU_SB_LINKLOST 5
`define STCU_SB_REPLY 6
`define STCU_SB_HOSTSP 7
`define STCU_SB_HOSTOFS 8

// ****************************************
// reset values and limits
// ****************************************
`define STCU_KEYSP_RST 16'h07D0
`define STCU_KEYOFS_RST 16'h0000
`define STCU_SP_MAX 16'd20000
`define STCU_SP_NEG_MAX 16'd5000
`define STCU_OFS_MAX 16'd255
`define STCU_BUF_LEN 10

// ****************************************
// characters
// ****************************************
`define STCU_CR 8'h0D
`define STCU_LF 8'h0A
`define STCU_SP 8'h20
`define STCU_PLUS 8'h2B
`define STCU_MINUS 8'h2D
`define STCU_DOT 8'h2E
`define STCU_USC 8'h5F
`define STCU_DOLLAR 8'h24
`define STCU_ZERO 8'h30

// ****************************************
// reply kinds
// ****************************************
`define STCU_R_NONE 3'h0
`define STCU_R_VER 3'h1
`define STCU_R_ACT 3'h2
`define STCU_R_SET 3'h3
`define STCU_R_OFS 3'h4
`define STCU_R_STAT 3'h5

`endif

// ==== test/stcu_host.sv ====
/*
 * host model: avalon-mm master that sends command lines and drains replies.
 * assumes the bench calls its tasks hierarchically and shares one clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "stcu_regs.vh"

module stcu_host (
   input wire logic clk_i,
   input wire logic wait_i,
   input wire logic [31:0] rdata_i,
   output logic [4:0] addr_o,
   output logic rd_o,
   output logic wr_o,
   output logic [31:0] wdata_o,
   output logic [3:0] be_o
);
   int gap = 0;
   logic [31:0] q;

   initial begin
      addr_o = 5'h0;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 32'h0;
      be_o = 4'h0;
   end

   // ****************************************
   // one bus cycle, held until waitrequest low
   // ****************************************
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      rd_o <= ~w;
      wr_o <= w;
      addr_o <= a;
      wdata_o <= d;
      be_o <= 4'hF;
      do begin
         @(posedge clk_i);
      end while (wait_i !== 1'b0);
      r = rdata_i;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      @(posedge clk_i);
      repeat (gap) @(posedge clk_i);
   endtask

   // letters sent exactly as given, line closed by cr
   task automatic line(input string s);
      foreach (s[i]) xfer(1'b1, `STCU_RXCHAR_OFS, {24'h0, s[i]}, q);
      xfer(1'b1, `STCU_RXCHAR_OFS, {24'h0, `STCU_CR}, q);
      repeat (3) @(posedge clk_i);
   endtask

   task automatic reply(output string s);
      s = "";
      repeat (16) begin
         xfer(1'b0, `STCU_TXCHAR_OFS, 32'h0, q);
         if (q[`STCU_TX_VALID_BIT] !== 1'b1) break;
         s = {s, string'(q[7:0])};
      end
   endtask
endmodule
`default_nettype wire

// ==== test/stcu_top_sva.sv ====
/*
 * checker for the command unit's ports.
 * assumes it is bound into stcu_top and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none

module stcu_chk (
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic AVS_WAITREQUEST_O,
   input wire logic [15:0] SETPOINT_O,
   input wire logic [15:0] OFFSET_O,
   input wire logic BARS_O,
   input wire logic REMOTE_O,
   input wire logic ENTER_BLOCK_O,
   input wire logic HEATER_O,
   input wire logic PUMP_O,
   input wire logic CTRL_RST_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);

   wait_pulse_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
      else $error("waitrequest low for more than one cycle");
   bus_answer_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
      |=> !AVS_WAITREQUEST_O) else $error("request not answered next cycle");
   wait_cause_a: assert property ($fell(AVS_WAITREQUEST_O) |-> $past(AVS_READ_I || AVS_WRITE_I))
      else $error("waitrequest low without request");
   pump_heater_a: assert property (HEATER_O |-> PUMP_O)
      else $error("heater on with pump off");
   rst_pulse_a: assert property (CTRL_RST_O |=> !CTRL_RST_O)
      else $error("controller reset longer than one cycle");
   lock_pair_a: assert property (REMOTE_O == ENTER_BLOCK_O)
      else $error("remote and enter block differ");
   value_range_a: assert property ($signed(SETPOINT_O) >= -5000 &&
      $signed(SETPOINT_O) <= 20000 && $signed(OFFSET_O) >= -255 && $signed(OFFSET_O) <= 255)
      else $error("setpoint or offset out of range");
   power_up_a: assert property ($fell(SYS_RST_I) |-> SETPOINT_O == $past(SETPOINT_O) &&
      OFFSET_O == $past(OFFSET_O) && !BARS_O && !HEATER_O && !PUMP_O)
      else $error("wrong state after power cycle");
   write_cause_a: assert property (($changed(SETPOINT_O) || $changed(OFFSET_O) ||
      $rose(BARS_O)) && !$past(SYS_RST_I) |-> $past(AVS_WRITE_I && !AVS_WAITREQUEST_O)
      || $past(AVS_WRITE_I && !AVS_WAITREQUEST_O, 2) || $past(AVS_WRITE_I && !AVS_WAITREQUEST_O, 3))
      else $error("setpoint or offset changed without a write");
endmodule

bind stcu_top stcu_chk i_chk (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .AVS_READ_I(AVS_READ_I),
   .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .SETPOINT_O(SETPOINT_O),
   .OFFSET_O(OFFSET_O), .BARS_O(BARS_O), .REMOTE_O(REMOTE_O), .ENTER_BLOCK_O(ENTER_BLOCK_O),
   .HEATER_O(HEATER_O), .PUMP_O(PUMP_O), .CTRL_RST_O(CTRL_RST_O));
`default_nettype wire

// ==== test/serial_thermostat_command_unit_bench.sv ====
/*
 * self-checking bench: host model sends command lines over avalon-mm.
 * assumes stcu_top, stcu_host and the bound checker are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
`include "stcu_regs.vh"

module serial_thermostat_command_unit_bench;
   logic clk = 1'b0, rst = 1'b1, lost = 1'b0, fault = 1'b0;
   logic [15:0] act = 16'hF6D7;
   logic [4:0] addr;
   logic rd, wr, waitreq, bars, remote, eblk, heat, pump, crst;
   logic [31:0] wdata, rdata, q;
   logic [3:0] be;
   logic [15:0] sp, ofs;
   int n_mismatch = 0, check_count = 0, cycles = 0, rs_seen = 0;
   string s;

   initial forever #5 clk = ~clk;

   stcu_top i_dut (.MCLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(waitreq), .ACT_TEMP_I(act), .LINK_LOST_I(lost), .FAULT_I(fault),
      .SETPOINT_O(sp), .OFFSET_O(ofs), .BARS_O(bars), .REMOTE_O(remote),
      .ENTER_BLOCK_O(eblk), .HEATER_O(heat), .PUMP_O(pump), .CTRL_RST_O(crst));
   stcu_host i_host (.clk_i(clk), .wait_i(waitreq), .rdata_i(rdata), .addr_o(addr),
      .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .be_o(be));

   // ****************************************
   // checking and closing
   // ****************************************
   function automatic logic [127:0] pk(input string x);
      logic [127:0] r;
      r = 128'h0;
      foreach (x[i]) r = {r[119:0], x[i]};
      return r;
   endfunction

   task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (crst === 1'b1) rs_seen <= rs_seen + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop;
      end
   end

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      i_host.xfer(1'b0, `STCU_STATUS_OFS, 32'h0, q);
      chk("status", q, 32'h0000_0010);
      i_host.xfer(1'b0, 5'h1C, 32'h0, q);
      chk("unmapped", q, 32'h0);
      chk("pump", pump, 1'b0);
      chk("sp init", sp, 16'h07D0);
      i_host.line("V");
      i_host.reply(s);
      chk("ver", pk(s.substr(s.len() - 3, s.len() - 1)), pk("$\015\012"));
      i_host.line("ER");
      i_host.line("GO");
      chk("heat", heat, 1'b1);
      i_host.line("st");
      chk("heat", heat, 1'b1);
      i_host.line("ST");
      chk("heat", {heat, pump}, 2'b01);
      i_host.line("GO");
      i_host.gap = 2;
      i_host.line("S   02345");
      chk("sp", sp, 16'h0929);
      chk("flags", {bars, remote, eblk}, 3'b111);
      i_host.gap = 0;
      i_host.line("S");
      i_host.reply(s);
      chk("sp reply", pk(s), pk("+0023.45_C$\015\012"));
      i_host.line("S   -1050");
      chk("sp", sp, 16'hFBE6);
      i_host.line("S   20001");
      chk("sp", sp, 16'hFBE6);
      i_host.line("c +0123");
      chk("ofs", ofs, 16'h007B);
      i_host.line("c  0255");
      chk("ofs", ofs, 16'h00FF);
      i_host.line("c +0256");
      chk("ofs", ofs, 16'h00FF);
      i_host.line("c -0120");
      i_host.line("c");
      i_host.reply(s);
      chk("ofs reply", pk(s), pk("-01.20_C$\015\012"));
      i_host.line("I");
      i_host.reply(s);
      chk("act reply", pk(s), pk("-0023.45_C$\015\012"));
      lost <= 1'b1;
      repeat (8) @(posedge clk);
      i_host.xfer(1'b0, `STCU_STATUS_OFS, 32'h0, q);
      chk("lost", q[5], 1'b1);
      chk("held", {sp, ofs}, 32'hFBE6_FF88);
      lost <= 1'b0;
      i_host.line("U");
      chk("remote", {remote, eblk}, 2'b00);
      i_host.line("L");
      chk("remote", {remote, eblk}, 2'b11);
      i_host.line("B");
      i_host.reply(s);
      chk("state", pk(s), pk("11100$\015\012"));
      i_host.line("AL");
      chk("alarm", {heat, pump}, 2'b00);
      i_host.xfer(1'b0, `STCU_STATUS_OFS, 32'h0, q);
      chk("alarm bit", q[3], 1'b1);
      i_host.line("ER");
      chk("pump", pump, 1'b1);
      i_host.line("U");
      i_host.xfer(1'b1, `STCU_KEYSP_OFS, 32'h0000_05DC, q);
      repeat (3) @(posedge clk);
      i_host.xfer(1'b0, `STCU_SETPT_OFS, 32'h0, q);
      chk("keypad sp", q[15:0], 16'h05DC);
      i_host.line("RS");
      chk("restart", rs_seen, 1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("power", {sp, ofs, bars}, {32'h05DC_0000, 1'b0});
      report_and_stop;
   end
endmodule
`default_nettype wire
